// ---- verilog/divided_quadrature_encoder_output.sv ----
/*
  Divided quadrature encoder output: turns motor position increments into
  A/B quadrature and a Z index, all as differential pairs.
  Assumes increments arrive on the system clock with a sample strobe, and
  the setting is sampled only at reset release (power cycle).
*/
module divided_quadrature_encoder_output
  import enc_out_pkg::*;
#(
  parameter int ENC_COUNTS = 1 << ENC_W  // Encoder counts per revolution
)
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Configuration, held stable
  input  wire logic [PPR_W-1:0]       pulses_per_rev_setting,
  input  wire logic                   useDefaultSetting,
  // Encoder position samples
  input  wire logic                   sampleValid,
  input  wire logic signed [INC_W-1:0] posIncrement,
  // Quadrature outputs
  output enc_out_pkg::quad_out_t      quadOut,
  // Status and alarms
  output enc_out_pkg::enc_status_t    status,
  output logic [11:0]                 alarmCode
);

  // ==========================================================
  // Settings latch
  // ==========================================================
  logic [PPR_W-1:0] pprActive_reg;
  logic             loaded_reg;
  logic             pprOk;

  // latch once after reset release
  // A change takes effect only after the next power cycle.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pprActive_reg <= PPR_DEFAULT;
      loaded_reg    <= 1'b0;
    end
    else if (!loaded_reg)
    begin
      loaded_reg <= 1'b1;
      if (!useDefaultSetting)
        pprActive_reg <= pulses_per_rev_setting;
    end
  end

  ppr_check uCheck
  (
    .pprValue (pprActive_reg),
    .pprOk    (pprOk)
  );

  // ==========================================================
  // Fractional divider
  // ==========================================================
  // Accumulator counts quarter-pulses: each encoder count adds 4*PPR,
  // one quadrature edge per ENC_COUNTS crossed.
  localparam int ACC_W = ENC_W + PPR_W + 4;
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] accSum;
  logic signed [ACC_W-1:0] encSpan;
  logic signed [7:0]       pend_reg;   // Pending edges, signed
  logic                    running;

  assign running = loaded_reg && pprOk;
  assign encSpan = ACC_W'(ENC_COUNTS);
  assign accSum  = acc_reg + ACC_W'(posIncrement)
                   * $signed({1'b0, pprActive_reg, 2'b00});

  // accumulate and count quarter crossings
  // Increment is small, so at most a few crossings per sample;
  // a loop-free compare pair handles one crossing each clock.
  logic stepUp;
  logic stepDown;
  logic edgeFire;
  logic edgeDir;      // 1 = clockwise
  logic [GAP_W-1:0] gap_reg;

  assign edgeFire = running && (pend_reg != 8'sh00) && (gap_reg == '0);
  assign edgeDir  = (pend_reg > 8'sh00);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg  <= '0;
      pend_reg <= 8'sh00;
      stepUp   <= 1'b0;
      stepDown <= 1'b0;
    end
    else if (running)
    begin
      stepUp   <= 1'b0;
      stepDown <= 1'b0;
      if (sampleValid)
        acc_reg <= accSum;
      // Backlog capped well inside the signed range, so a long
      // overspeed never wraps the count and reverses the phases
      else if (acc_reg >= encSpan && pend_reg < 8'sh40)
      begin
        acc_reg <= acc_reg - encSpan;
        stepUp  <= 1'b1;
      end
      else if (acc_reg < 0 && pend_reg > -8'sh40)
      begin
        acc_reg  <= acc_reg + encSpan;
        stepDown <= 1'b1;
      end
      // Pending edges: new crossings in, fired edges out
      pend_reg <= pend_reg + 8'(stepUp) - 8'(stepDown)
                  - (edgeFire ? (edgeDir ? 8'sh01 : -8'sh01) : 8'sh00);
    end
  end

  // ==========================================================
  // Rate limiter and overspeed
  // ==========================================================
  logic overspeed_reg;

  // edges spaced by at least the 6.4 MHz period
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      gap_reg <= '0;
    else if (edgeFire)
      gap_reg <= GAP_W'(MIN_EDGE_CYC - 1);
    else if (gap_reg != '0)
      gap_reg <= gap_reg - 1'b1;
  end

  // backlog beyond limit raises alarm 511, held until reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      overspeed_reg <= 1'b0;
    else if (pend_reg > 8'sh08 || pend_reg < -8'sh08)
      overspeed_reg <= 1'b1;
  end

  // ==========================================================
  // Quadrature state
  // ==========================================================
  logic [1:0] quad_reg;   // Binary phase count, decoded to Gray
  logic       phA;
  logic       phB;

  // clockwise counts up so A leads; counter-clockwise down, B leads
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      quad_reg <= 2'h0;
    else if (edgeFire)
      quad_reg <= edgeDir ? quad_reg + 2'h1 : quad_reg - 2'h1;
  end

  // Gray sequence 00,10,11,01 gives A then B when counting up
  assign phA = (quad_reg == 2'h1) || (quad_reg == 2'h2);
  assign phB = (quad_reg == 2'h2) || (quad_reg == 2'h3);

  // ==========================================================
  // Index generation
  // ==========================================================
  logic [PPR_W+1:0] edgeCnt_reg;  // Quarter edges within one revolution
  logic [1:0]       revSeen_reg;
  logic             phZ;
  logic [PPR_W+1:0] revEdges;

  assign revEdges = {pprActive_reg, 2'b00};

  // count edges per revolution, wrap in both directions
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      edgeCnt_reg <= '0;
      revSeen_reg <= 2'h0;
    end
    else if (edgeFire)
    begin
      if (edgeDir)
      begin
        if (edgeCnt_reg == revEdges - 1'b1)
        begin
          edgeCnt_reg <= '0;
          // index trusted after two edge-count wraps, in either direction
          if (revSeen_reg != 2'(INDEX_SETTLE_REV))
            revSeen_reg <= revSeen_reg + 2'h1;
        end
        else
          edgeCnt_reg <= edgeCnt_reg + 1'b1;
      end
      else if (edgeCnt_reg == '0)
      begin
        edgeCnt_reg <= revEdges - 1'b1;
        if (revSeen_reg != 2'(INDEX_SETTLE_REV))
          revSeen_reg <= revSeen_reg + 2'h1;
      end
      else
        edgeCnt_reg <= edgeCnt_reg - 1'b1;
    end
  end

  // Z high across the first A pulse of each revolution
  assign phZ = (edgeCnt_reg == 1) || (edgeCnt_reg == 2);

  // ==========================================================
  // Output registers
  // ==========================================================
  // registered differential drive of A, B and Z
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quadOut <= '{phaseA: '{1'b0, 1'b1}, phaseB: '{1'b0, 1'b1},
                   phaseZ: '{1'b0, 1'b1}};
      status    <= '0;
      alarmCode <= 12'h000;
    end
    else
    begin
      quadOut.phaseA <= '{phA, ~phA};
      quadOut.phaseB <= '{phB, ~phB};
      quadOut.phaseZ <= '{phZ, ~phZ};
      status.settingErr <= loaded_reg && !pprOk;
      status.overspeed  <= overspeed_reg;
      status.indexValid <= (revSeen_reg == 2'(INDEX_SETTLE_REV));
      // setting alarm takes priority over overspeed
      if (loaded_reg && !pprOk)
        alarmCode <= ALM_SETTING;
      else if (overspeed_reg)
        alarmCode <= ALM_OVERSPEED;
      else
        alarmCode <= 12'h000;
    end
  end

endmodule

// ---- verilog/enc_out_pkg.sv ----
/*
  Package for the divided quadrature encoder output block: widths,
  reset values, setting limits, timing figures and carrier structs.
  Assumes a single 200 MHz system clock and no software register access.
*/
package enc_out_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_HZ          = 200_000_000;
  localparam int MAX_RATE_PPS    = 1_600_000;       // Per phase
  localparam int MAX_EDGE_HZ     = 4 * MAX_RATE_PPS; // 6.4 MHz edges
  // Least spacing between two output edges, rounded up
  localparam int MIN_EDGE_CYC    = (CLK_HZ + MAX_EDGE_HZ - 1) / MAX_EDGE_HZ;
  localparam int GAP_W           = 8;

  // ==========================================================
  // Setting limits and reset value
  // ==========================================================
  localparam int PPR_W           = 21;
  localparam logic [20:0] PPR_MIN     = 21'h00_0010;   // 16
  localparam logic [20:0] PPR_MAX     = 21'h10_0000;   // 1048576
  localparam logic [20:0] PPR_DEFAULT = 21'h00_0800;   // 2048
  localparam logic [20:0] PPR_STEP1_TOP = 21'h00_4000; // 16384

  // Encoder position resolution per revolution
  localparam int ENC_W           = 24;
  localparam int INC_W           = 8;  // Signed increment per sample

  // Index settling: two edge-count wraps after restart, either direction
  localparam int INDEX_SETTLE_REV = 2;

  // Alarm codes
  localparam logic [11:0] ALM_SETTING   = 12'h041;
  localparam logic [11:0] ALM_OVERSPEED = 12'h511;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic posP;
    logic posN;
  } diff_pair_t;

  typedef struct packed {
    diff_pair_t phaseA;
    diff_pair_t phaseB;
    diff_pair_t phaseZ;
  } quad_out_t;

  typedef struct packed {
    logic settingErr;   // Alarm 041
    logic overspeed;    // Alarm 511
    logic indexValid;
  } enc_status_t;

endpackage

// ---- verilog/ppr_check.sv ----
/*
  Checks the pulses-per-revolution setting against its range and step.
  Assumes a stable setting input; purely combinational.
*/
module ppr_check
  import enc_out_pkg::*;
(
  // Setting under test
  input  wire logic [PPR_W-1:0] pprValue,
  // Result
  output logic                  pprOk
);

  // ==========================================================
  // Step check
  // ==========================================================
  // Required step doubles with each range above 16384
  function automatic logic stepOk(input logic [PPR_W-1:0] v);
    logic [PPR_W-1:0] mask;
    mask = '0;
    if (v <= PPR_STEP1_TOP)
      mask = 21'h00_0000;
    else if (v <= 21'h00_8000)
      mask = 21'h00_0001;
    else if (v <= 21'h01_0000)
      mask = 21'h00_0003;
    else if (v <= 21'h02_0000)
      mask = 21'h00_0007;
    else if (v <= 21'h04_0000)
      mask = 21'h00_000F;
    else if (v <= 21'h08_0000)
      mask = 21'h00_001F;
    else
      mask = 21'h00_003F;
    return (v & mask) == '0;
  endfunction

  // Range and granularity together
  assign pprOk = (pprValue >= PPR_MIN) && (pprValue <= PPR_MAX)
                 && stepOk(pprValue);

endmodule

// ---- verif/enc_out_sva.sv ----
/* Checker for the divided encoder output.
   Sees only the top ports; bound at the foot. */
module enc_out_sva
  import enc_out_pkg::*;
#(
  parameter int ENC_COUNTS = 64
)
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // Outputs watched
  input wire enc_out_pkg::quad_out_t   quadOut,
  input wire enc_out_pkg::enc_status_t status,
  input wire logic [11:0]        alarmCode
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MIN_GAP = MIN_EDGE_CYC - 1;
  logic [1:0] abReg;
  logic [5:0] gapReg;
  logic [1:0] abNow;
  assign abNow = {quadOut.phaseA.posP, quadOut.phaseB.posP};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // =====================================================
  // Edge tracking
  // =====================================================
  // Saturating gap counter, so a long idle never wraps
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      gapReg <= 6'h3F;
    else if (abNow != abReg)
      gapReg <= 6'h00;
    else if (gapReg != 6'h3F)
      gapReg <= gapReg + 6'h01;
  // Last phase levels
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      abReg <= 2'h0;
    else
      abReg <= abNow;
  sequence s_ab_edge;
    abNow != abReg;
  endsequence
  a_diff_a: assert property (quadOut.phaseA.posN != quadOut.phaseA.posP)
    else $error("phase A pair not complementary");
  a_diff_b: assert property (quadOut.phaseB.posN != quadOut.phaseB.posP)
    else $error("phase B pair not complementary");
  a_diff_z: assert property (quadOut.phaseZ.posN != quadOut.phaseZ.posP)
    else $error("index pair not complementary");
  a_one_phase: assert property (s_ab_edge |-> $onehot(abNow ^ abReg))
    else $error("both phases moved together");
  a_edge_gap: assert property (s_ab_edge |-> gapReg >= MIN_GAP)
    else $error("edges closer than rate limit");
  a_setting_code: assert property (status.settingErr |-> alarmCode == ALM_SETTING)
    else $error("setting alarm code wrong");
  a_refuse_move: assert property (status.settingErr |-> abNow == abReg)
    else $error("phases moved with bad setting");
  a_over_code: assert property (status.overspeed && !status.settingErr
    |-> alarmCode == ALM_OVERSPEED)
    else $error("overspeed alarm code wrong");
  a_alarm_clear: assert property (!status.settingErr && !status.overspeed
    |-> alarmCode == 12'h000)
    else $error("alarm code without cause");
  a_over_sticky: assert property ($rose(status.overspeed)
    |=> status.overspeed [*8])
    else $error("overspeed alarm dropped");
endmodule
bind divided_quadrature_encoder_output enc_out_sva #(.ENC_COUNTS(ENC_COUNTS))
  u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .quadOut(quadOut),
  .status(status), .alarmCode(alarmCode));

// ---- verif/host_counter.sv ----
/* Host pulse counter model: 4x decode of the quadrature.
   Assumes registered phase levels on the system clock. */
module host_counter
  import enc_out_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // Quadrature from the device
  input wire enc_out_pkg::quad_out_t quadOut,
  // Counts seen
  output int                     posCount,
  output int                     aRises,
  output int                     zPulses,
  output int                     aHighW,
  output int                     zHighW
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] abReg;
  logic       zReg;
  logic [1:0] abNow;
  logic       fwd;
  assign abNow = {quadOut.phaseA.posP, quadOut.phaseB.posP};
  assign fwd = (abNow == {~abReg[0], abReg[1]});
  // =====================================================
  // Decode
  // =====================================================
  // counts, widths
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      {abReg, zReg} = 3'h0;
      {posCount, aRises, zPulses, aHighW, zHighW} = '0;
    end
    else
    begin
      if (abNow != abReg)
        posCount += fwd ? 1 : -1;
      aRises += (abNow[1] && !abReg[1]);
      zPulses += (quadOut.phaseZ.posP && !zReg);
      // Widths measured in cycles; reset on each rise
      aHighW = abNow[1] ? (abReg[1] ? aHighW + 1 : 1) : aHighW;
      zHighW = quadOut.phaseZ.posP ? (zReg ? zHighW + 1 : 1) : zHighW;
      abReg = abNow;
      zReg = quadOut.phaseZ.posP;
    end
endmodule

// ---- verif/tb_divided_quadrature_encoder_output.sv ----
/* Self-checking bench for the divided encoder output.
   Assumes the host model and the bound checker. */
module tb_divided_quadrature_encoder_output;
  timeunit 1ns;
  timeprecision 100ps;
  import enc_out_pkg::*;
  localparam int ENC = 64;
  localparam int PPR = 16;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [PPR_W-1:0] pulses_per_rev_setting = 21'h00_0010;
  logic useDefaultSetting = 1'b0;
  logic sampleValid = 1'b0;
  logic signed [INC_W-1:0] posIncrement = 8'h00;
  quad_out_t quadOut;
  enc_status_t status;
  logic [11:0] alarmCode;
  int posCount, aRises, zPulses, aHighW, zHighW, zs;
  int num_errors = 0;
  int checked = 0;
  int tbl[$] = '{16, 15, 16384, 16385, 16386, 32770, 32772, 524320,
                 524352, 1048576, 1048577};
  always #2.5 clk_sys = ~clk_sys;
  divided_quadrature_encoder_output #(.ENC_COUNTS(ENC)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .pulses_per_rev_setting(pulses_per_rev_setting),
    .useDefaultSetting(useDefaultSetting), .sampleValid(sampleValid),
    .posIncrement(posIncrement), .quadOut(quadOut), .status(status),
    .alarmCode(alarmCode));
  host_counter host (.clk_sys(clk_sys), .rst_n(rst_n), .quadOut(quadOut),
    .posCount(posCount), .aRises(aRises), .zPulses(zPulses),
    .aHighW(aHighW), .zHighW(zHighW));
  // =====================================================
  // Tasks
  // =====================================================
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (exp !== got)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Setting is only taken at reset release
  task automatic restart(int set, logic def);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    pulses_per_rev_setting <= set[PPR_W-1:0];
    useDefaultSetting <= def;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic step(int inc, int gap);
    @(posedge clk_sys);
    sampleValid <= 1'b1;
    posIncrement <= inc[INC_W-1:0];
    @(posedge clk_sys);
    sampleValid <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask
  // gaps keep the edge rate well under the limit
  task automatic rev(int inc, int n, bit fixed);
    repeat (n * ENC)
      step(inc, fixed ? 40 : $urandom_range(70, 40));
    repeat (100) @(posedge clk_sys);
  endtask
  function automatic bit ppr_ok(int v);
    int k;
    k = 0;
    if (v < 16 || v > 1048576)
      return 0;
    while (v > (16384 << k))
      k++;
    return (v % (1 << k)) == 0;
  endfunction
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
  // =====================================================
  // Main sequence
  // =====================================================
  initial
  begin
    void'($urandom(32'h5C61));
    repeat (4)
      tbl.push_back($urandom_range(1048600, 10));
    foreach (tbl[i])
    begin
      restart(tbl[i], 1'b0);
      check("settingErr", !ppr_ok(tbl[i]), status.settingErr);
      check("alarmCode", ppr_ok(tbl[i]) ? 0 : ALM_SETTING, alarmCode);
    end
    restart(15, 1'b1);
    check("default", 0, status.settingErr);
    restart(15, 1'b0);
    rev(1, 1, 1'b0);
    check("refused", 0, posCount);
    restart(PPR, 1'b0);
    rev(1, 2, 1'b0);
    check("posCount", 2 * 4 * PPR, posCount);
    check("aRises", 2 * PPR, aRises);
    check("indexValid", 1, status.indexValid);
    // A new setting without a power cycle must stay unused
    pulses_per_rev_setting <= 21'h00_000F;
    repeat (4) @(posedge clk_sys);
    #1;
    check("latched", 0, status.settingErr);
    zs = zPulses;
    rev(1, 1, 1'b1);
    check("zPulses", 1, zPulses - zs);
    check("zWidth", aHighW, zHighW);
    rev(-1, 1, 1'b0);
    check("ccwCount", 2 * 4 * PPR, posCount);
    repeat (4)
      step(40, 0);
    for (int i = 0; i < 50 && status.overspeed !== 1'b1; i++)
      @(posedge clk_sys);
    #1;
    // Bound used up: count it and report at once
    if (status.overspeed !== 1'b1)
    begin
      num_errors++;
      give_verdict();
    end
    check("overspeed", 1, status.overspeed);
    check("alarm511", ALM_OVERSPEED, alarmCode);
    repeat (60) @(posedge clk_sys);
    check("sticky", 1, status.overspeed);
    give_verdict();
  end
endmodule
